// ### core/mpv_pkg.sv
// Shared constants and carrier types for the multipurpose pin value block.
// Assumes a 16-bit control-port address space and 16-bit register data.
package mpv_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_PINS = 14;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned IDX_W = 4;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [15:0] PIN_VALUE_OVERRIDE_REG_BASE = 16'hF520;
  localparam logic [15:0] PIN_VALUE_OVERRIDE_REG_LAST = 16'hF52D;
  localparam logic [15:0] PIN_LEVEL_REG_BASE = 16'hF530;
  localparam logic [15:0] PIN_LEVEL_REG_LAST = 16'hF53D;
  localparam logic [15:0] REG_RESET = 16'h0000;

  // ----------------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------------
  localparam int unsigned CORE_VALUE_BIT_POS = 0;
  localparam int unsigned PIN_LEVEL_BIT_POS = 0;

  // ----------------------------------------------------------------------
  // Pin function select codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] FUNC_DIGITAL_INPUT = 3'h0;
  localparam logic [2:0] FUNC_PORT_DRIVEN = 3'h1;

  // One pin's configuration as held by the pin mode registers elsewhere.
  typedef struct packed {
    logic [2:0] pin_function_select;
    logic multifunction_enable;
  } mpv_pin_cfg_t;

  // A control-port access.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mpv_access_t;

endpackage

// ### core/mpv_pin_values.sv
// Multipurpose pin value registers: override values for the DSP core and
// sampled pin levels, reached through the control port register access.
// Assumes pin configuration comes from logic on the same clock and that the
// pins themselves are asynchronous to it.
`timescale 1ns/1ns

module mpv_pin_values (
  // Clock, reset and enable
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  // Control port register access
  input wire mpv_pkg::mpv_access_t i_access,
  output logic [15:0] o_rdata,
  // Pin configuration from the mode registers
  input wire mpv_pkg::mpv_pin_cfg_t i_pin_cfg [mpv_pkg::NUM_PINS],
  // External pins
  input wire logic [13:0] i_pin,
  // DSP core pin values
  output logic [13:0] o_core_value
);

  // ----------------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------------
  function automatic logic in_range(input logic [15:0] addr,
                                    input logic [15:0] first,
                                    input logic [15:0] last);
    in_range = (addr >= first) && (addr <= last);
  endfunction

  function automatic logic [3:0] reg_index(input logic [15:0] addr,
                                           input logic [15:0] base);
    logic [15:0] diff;
    diff = addr - base;
    reg_index = diff[3:0];
  endfunction

  function automatic logic is_input(input mpv_pkg::mpv_pin_cfg_t cfg);
    is_input = cfg.multifunction_enable &&
      (cfg.pin_function_select == mpv_pkg::FUNC_DIGITAL_INPUT ||
       cfg.pin_function_select == mpv_pkg::FUNC_PORT_DRIVEN);
  endfunction

  logic wr_ovr_hit;
  logic rd_ovr_hit;
  logic rd_lvl_hit;
  logic [3:0] ovr_idx;
  logic [3:0] lvl_idx;

  assign wr_ovr_hit = i_access.wr && in_range(i_access.addr,
    mpv_pkg::PIN_VALUE_OVERRIDE_REG_BASE,
    mpv_pkg::PIN_VALUE_OVERRIDE_REG_LAST);
  assign rd_ovr_hit = i_access.rd && in_range(i_access.addr,
    mpv_pkg::PIN_VALUE_OVERRIDE_REG_BASE,
    mpv_pkg::PIN_VALUE_OVERRIDE_REG_LAST);
  assign rd_lvl_hit = i_access.rd && in_range(i_access.addr,
    mpv_pkg::PIN_LEVEL_REG_BASE, mpv_pkg::PIN_LEVEL_REG_LAST);
  assign ovr_idx = reg_index(i_access.addr,
    mpv_pkg::PIN_VALUE_OVERRIDE_REG_BASE);
  assign lvl_idx = reg_index(i_access.addr, mpv_pkg::PIN_LEVEL_REG_BASE);

  // ----------------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------------
  // Pins are asynchronous, so only the second stage is read by logic.
  logic [13:0] pin_meta;
  logic [13:0] pin_sync;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else if (i_clk_en) begin
      pin_meta <= i_pin;
      pin_sync <= pin_meta;
    end
  end

  // ----------------------------------------------------------------------
  // Override registers
  // ----------------------------------------------------------------------
  // Only bit 0 has meaning; reserved bits are written zero and are never
  // read back, so they are not stored.
  logic [13:0] core_value_bit;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      core_value_bit <= mpv_pkg::REG_RESET[13:0];
    end else if (i_clk_en && wr_ovr_hit) begin
      core_value_bit[ovr_idx] <=
        i_access.wdata[mpv_pkg::CORE_VALUE_BIT_POS];
    end
  end

  // ----------------------------------------------------------------------
  // Pin level registers
  // ----------------------------------------------------------------------
  // A pin not in an input function keeps its last sampled level.
  // Function 001 counts as an input as well, so its pin stays readable
  // here while the core is shown the override value instead.
  logic [13:0] pin_level_bit;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pin_level_bit <= mpv_pkg::REG_RESET[13:0];
    end else if (i_clk_en) begin
      for (int k = 0; k < 14; k++) begin
        if (is_input(i_pin_cfg[k])) begin
          pin_level_bit[k] <= pin_sync[k];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Values presented to the DSP core
  // ----------------------------------------------------------------------
  logic [13:0] next_core_value;

  always_comb begin
    for (int k = 0; k < 14; k++) begin
      next_core_value[k] = 1'b0;
      if (i_pin_cfg[k].multifunction_enable) begin
        if (i_pin_cfg[k].pin_function_select ==
            mpv_pkg::FUNC_PORT_DRIVEN) begin
          next_core_value[k] = core_value_bit[k];
        end else if (i_pin_cfg[k].pin_function_select ==
                     mpv_pkg::FUNC_DIGITAL_INPUT) begin
          next_core_value[k] = pin_sync[k];
        end
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_core_value <= '0;
    end else if (i_clk_en) begin
      o_core_value <= next_core_value;
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  // Write-only and unmapped addresses answer zero.
  // Reads answer one enabled cycle after the request, with no wait state.
  logic [15:0] next_rdata;

  always_comb begin
    next_rdata = '0;
    if (rd_lvl_hit) begin
      next_rdata[mpv_pkg::PIN_LEVEL_BIT_POS] =
        pin_level_bit[lvl_idx];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_rdata <= mpv_pkg::REG_RESET;
    end else if (i_clk_en) begin
      o_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking

  // The last taken write is remembered here so that a_ovr_store can check
  // the stored bit one cycle later without a deep $past chain.
  logic [3:0] wr_idx_q;
  logic wr_bit_q;
  logic wr_seen_q;

  always_ff @(posedge i_clock) begin
    wr_seen_q <= !i_rst && i_clk_en && wr_ovr_hit;
    wr_idx_q <= ovr_idx;
    wr_bit_q <= i_access.wdata[mpv_pkg::CORE_VALUE_BIT_POS];
  end

  a_ovr_store: assert property (
    disable iff (i_rst) wr_seen_q |-> core_value_bit[wr_idx_q] == wr_bit_q)
    else $error("override write not stored");

  a_reset_clear: assert property (
    i_rst |=> o_core_value == 14'h0000 && o_rdata == 16'h0000 &&
      core_value_bit == 14'h0000 && pin_level_bit == 14'h0000)
    else $error("reset did not clear registers");

  a_rsvd_zero: assert property (
    disable iff (i_rst) o_rdata[15:1] == 15'h0000)
    else $error("reserved read bits not zero");

  a_wo_reads_zero: assert property (
    disable iff (i_rst) i_clk_en && rd_ovr_hit |=> o_rdata == 16'h0000)
    else $error("write-only register read back nonzero");

  // Reset is also tested in the antecedent by its sampled value, because
  // disable iff sees the current value and lets the release edge through.
  a_ovr_hold: assert property (
    disable iff (i_rst)
    !i_rst && !(i_clk_en && wr_ovr_hit) |=> $stable(core_value_bit))
    else $error("override changed without a write");

  a_rdata_idle: assert property (
    disable iff (i_rst) i_clk_en && !rd_lvl_hit |=> o_rdata == 16'h0000)
    else $error("read data not zero outside a level read");

  for (genvar k = 0; k < 14; k++) begin : g_pin_chk
    // Each pin gets its own checks, so a failure names the pin's scope.
    logic in_k;
    logic port_k;
    logic dig_k;
    assign in_k = is_input(i_pin_cfg[k]);
    assign port_k = i_pin_cfg[k].multifunction_enable &&
      i_pin_cfg[k].pin_function_select == mpv_pkg::FUNC_PORT_DRIVEN;
    assign dig_k = i_pin_cfg[k].multifunction_enable &&
      i_pin_cfg[k].pin_function_select == mpv_pkg::FUNC_DIGITAL_INPUT;

    a_core_port: assert property (
      disable iff (i_rst)
      i_clk_en && port_k |=> o_core_value[k] == $past(core_value_bit[k]))
      else $error("core value not taken from override");

    a_ovr_to_core: assert property (
      disable iff (i_rst)
      (i_clk_en && wr_ovr_hit && ovr_idx == k && port_k) ##1
        (i_clk_en && port_k) |=>
        o_core_value[k] == $past(i_access.wdata[0], 2))
      else $error("written value not seen by the core");

    a_level_track: assert property (
      disable iff (i_rst)
      (i_clk_en && in_k)[*4] |-> pin_level_bit[k] == $past(i_pin[k], 3))
      else $error("level bit does not follow pin");

    a_level_frozen: assert property (
      disable iff (i_rst)
      !i_rst && !(i_clk_en && in_k) |=> $stable(pin_level_bit[k]))
      else $error("level bit moved outside an input function");

    a_pin_to_core: assert property (
      disable iff (i_rst)
      (i_clk_en && dig_k)[*4] |-> o_core_value[k] == $past(i_pin[k], 3))
      else $error("core value does not follow input pin");

    a_level_read: assert property (
      disable iff (i_rst)
      i_clk_en && rd_lvl_hit && lvl_idx == k |=>
        o_rdata == {15'h0000, $past(pin_level_bit[k])})
      else $error("level read returned wrong value");

    a_core_input: assert property (
      disable iff (i_rst)
      i_clk_en && i_pin_cfg[k].multifunction_enable &&
      i_pin_cfg[k].pin_function_select == 3'h0 |=>
        o_core_value[k] == $past(pin_sync[k]))
      else $error("input function does not pass pin");

    a_core_disabled: assert property (
      disable iff (i_rst)
      i_clk_en && !i_pin_cfg[k].multifunction_enable |=>
        o_core_value[k] == 1'b0)
      else $error("disabled pin reaches core");

    a_core_other: assert property (
      disable iff (i_rst)
      i_clk_en && i_pin_cfg[k].multifunction_enable &&
      i_pin_cfg[k].pin_function_select > 3'h1 |=> o_core_value[k] == 1'b0)
      else $error("other function reaches core");
  end

  // ----------------------------------------------------------------------
  // Cover properties
  // ----------------------------------------------------------------------
  // These mark the main scenarios, so a bench that skips one shows it.
  c_ovr_write: cover property (
    disable iff (i_rst) i_clk_en && wr_ovr_hit && i_access.wdata[0]);
  c_level_read_high: cover property (
    disable iff (i_rst) i_clk_en && rd_lvl_hit ##1 o_rdata[0]);
  c_core_high: cover property (
    disable iff (i_rst) o_core_value != 14'h0000);
  c_freeze: cover property (
    disable iff (i_rst) !i_clk_en && wr_ovr_hit);
  c_other_func: cover property (
    disable iff (i_rst) i_pin_cfg[0].multifunction_enable &&
      i_pin_cfg[0].pin_function_select > mpv_pkg::FUNC_PORT_DRIVEN);

endmodule

// ### test/mpv_pin_model.sv
// Model of the external pins that feed the multipurpose pin block.
// Assumes the bench sets the wanted levels; pins move just after an edge.
`timescale 1ns/1ns

module mpv_pin_model (
  // Clock
  input wire logic i_clock,
  // Levels requested by the bench
  input wire logic [13:0] i_level,
  // External pins
  output logic [13:0] o_pin
);
  // Launched from a flop so a pin changes only at a clock edge, after that edge has sampled it.
  always @(posedge i_clock) begin
    o_pin <= i_level;
  end
endmodule

// ### test/testbench.sv
// Self-checking bench for the multipurpose pin value registers.
// Assumes the pin model above drives the pins and the bench the port.
`timescale 1ns/1ns

module testbench;
  logic i_clock;
  logic i_rst;
  logic i_clk_en;
  mpv_pkg::mpv_access_t acc;
  logic [15:0] rdata;
  mpv_pkg::mpv_pin_cfg_t cfg [mpv_pkg::NUM_PINS];
  logic [13:0] level;
  logic [13:0] pin;
  logic [13:0] core;
  int num_errors;
  int compares;

  mpv_pin_model i_mpv_pin_model (.i_clock(i_clock), .i_level(level),
    .o_pin(pin));
  mpv_pin_values i_mpv_pin_values (.i_clock(i_clock), .i_rst(i_rst),
    .i_clk_en(i_clk_en), .i_access(acc), .o_rdata(rdata),
    .i_pin_cfg(cfg), .i_pin(pin), .o_core_value(core));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One access; read data is settled just after the taking edge.
  task automatic access(input logic wr, input logic rd,
                        input logic [15:0] addr, input logic [15:0] data);
    @(posedge i_clock);
    acc <= {wr, rd, addr, data};
    @(posedge i_clock);
    acc <= '0;
    #1;
  endtask

  task automatic set_cfg(input logic [2:0] func, input logic en);
    @(posedge i_clock);
    for (int k = 0; k < 14; k++) begin
      cfg[k] <= {func, en};
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    check({2'h0, core}, 16'h0000);
    for (int k = 0; k < 14; k++) begin
      access(1'b0, 1'b1, 16'hF530 + 16'(k), 16'h0000);
      check(rdata, 16'h0000);
    end
  endtask

  task automatic t_override();
    set_cfg(mpv_pkg::FUNC_PORT_DRIVEN, 1'b1);
    for (int k = 0; k < 14; k++) begin
      access(1'b1, 1'b0, 16'hF520 + 16'(k), 16'h0001);
      wait_n(1);
      check({2'h0, core}, 16'h0001 << k);
      access(1'b0, 1'b1, 16'hF520 + 16'(k), 16'h0000);
      check(rdata, 16'h0000);
      access(1'b1, 1'b0, 16'hF520 + 16'(k), 16'h0000);
      wait_n(1);
      check({2'h0, core}, 16'h0000);
    end
  endtask

  task automatic t_level(input logic [13:0] pat);
    set_cfg(mpv_pkg::FUNC_DIGITAL_INPUT, 1'b1);
    level <= pat;
    wait_n(5);
    check({2'h0, core}, {2'h0, pat});
    for (int k = 0; k < 14; k++) begin
      access(1'b0, 1'b1, 16'hF530 + 16'(k), 16'h0000);
      check(rdata, {15'h0000, pat[k]});
    end
  endtask

  task automatic t_other();
    set_cfg(3'h2, 1'b1);
    for (int k = 0; k < 14; k++) begin
      access(1'b1, 1'b0, 16'hF520 + 16'(k), 16'h0001);
    end
    wait_n(2);
    check({2'h0, core}, 16'h0000);
    set_cfg(mpv_pkg::FUNC_PORT_DRIVEN, 1'b1);
    wait_n(2);
    check({2'h0, core}, 16'h3FFF);
  endtask

  task automatic t_disabled();
    set_cfg(mpv_pkg::FUNC_PORT_DRIVEN, 1'b0);
    wait_n(2);
    check({2'h0, core}, 16'h0000);
    level <= 14'h0000;
    wait_n(5);
    access(1'b0, 1'b1, 16'hF531, 16'h0000);
    check(rdata, 16'h0001);
  endtask

  // Accesses with the enable low, and beyond the last pin, are refused.
  task automatic t_refuse();
    set_cfg(mpv_pkg::FUNC_PORT_DRIVEN, 1'b1);
    i_clk_en <= 1'b0;
    access(1'b1, 1'b0, 16'hF520, 16'h0000);
    @(posedge i_clock);
    i_clk_en <= 1'b1;
    wait_n(2);
    check({2'h0, core}, 16'h3FFF);
    access(1'b0, 1'b1, 16'hF53E, 16'h0000);
    check(rdata, 16'h0000);
  endtask

  // A reset in mid-run clears the overrides of port-driven pins.
  task automatic t_mid_reset();
    @(posedge i_clock);
    i_rst <= 1'b1;
    wait_n(2);
    check({2'h0, core}, 16'h0000);
    @(posedge i_clock);
    i_rst <= 1'b0;
    wait_n(2);
    check({2'h0, core}, 16'h0000);
    access(1'b1, 1'b0, 16'hF52D, 16'h0001);
    wait_n(1);
    check({2'h0, core}, 16'h2000);
  endtask

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  initial begin
    i_rst = 1'b1;
    i_clk_en = 1'b1;
    acc = '0;
    level = 14'h0000;
    num_errors = 0;
    compares = 0;
    for (int k = 0; k < 14; k++) begin
      cfg[k] = '0;
    end
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    wait_n(1);
    t_reset();
    t_override();
    t_level(14'h2A55);
    t_level(14'h15AA);
    t_other();
    t_disabled();
    t_refuse();
    t_mid_reset();
    close_out();
  end
endmodule
